// ==== rtl/cwp_pkg.sv ====
// Behaviour
// - bit31 gives power-enable pin to USB
// - bit30 gives ident pin to USB
// - bit29 limits pin-select to one change
// - bit28 limits module-disable to one change
// - bits 27..16 always read zero
// - low 16 bits are user tag, host-readable
// - overvoltage disables the power-enable pin output (ident pins stay driven) and holds reset
// - startup delay inhibits execution after power-down
// - low regulator input gives brownout, sets flag
package cwp_pkg;
    // =========================================================
    // configuration word layout
    localparam int CWP_POWER_SEL_BIT = 31;
    localparam int CWP_IDENT_SEL_BIT = 30;
    localparam int CWP_PPS_ONE_BIT = 29;
    localparam int CWP_PMD_ONE_BIT = 28;
    localparam logic [31:0] CWP_IMPL_MASK = 32'hf000_ffff;
    localparam logic [31:0] CWP_WORD_RESET = 32'h0000_0000;
    localparam int CWP_TAG_W = 16;
    // =========================================================
    // reset-cause register
    localparam int CWP_CAUSE_BROWNOUT_BIT = 1;
    localparam logic [31:0] CWP_CAUSE_RESET = 32'h0000_0000;
    // =========================================================
    // regulator start-up delay
    localparam int CWP_CLK_MHZ = 50;
    localparam int CWP_STARTUP_US = 10;
    localparam int CWP_STARTUP_CYC = CWP_STARTUP_US * CWP_CLK_MHZ;
    localparam int CWP_CNT_W = 16;
endpackage

// ==== rtl/cwp_word_store.sv ====
`timescale 1ns/100ps
// holds the configuration word; captured from storage at reset release
module cwp_word_store
    import cwp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // load side
    input wire logic load_i,
    input wire logic [31:0] nv_word_i,
    // read side
    output logic [31:0] word_o
);
    // =========================================================
    // storage
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            word_o <= CWP_WORD_RESET;
        end else if (load_i) begin
            word_o <= nv_word_i & CWP_IMPL_MASK;
        end
    end
endmodule

// ==== rtl/cwp_config_word.sv ====
`timescale 1ns/100ps
module cwp_config_word
    import cwp_pkg::*;
#(
    parameter int STARTUP_CYCLES = CWP_STARTUP_CYC
)
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // non-volatile source
    input wire logic [31:0] nv_word_i,
    // supply monitors
    input wire logic core_overvoltage_detect_i,
    input wire logic regulator_low_i,
    input wire logic power_down_exit_i,
    input wire logic cause_clear_i,
    // pin ownership sources
    input wire logic usb_bus_power_i,
    input wire logic port_bus_power_i,
    input wire logic otg_ident_input_i,
    // reconfiguration requests
    input wire logic pps_write_i,
    input wire logic pmd_write_i,
    // decoded word
    output logic [31:0] device_config_word_three_o,
    output logic [CWP_TAG_W-1:0] user_tag_value_o,
    output logic power_enable_pin_owner_sel_o,
    output logic otg_ident_pin_owner_sel_o,
    output logic pin_select_single_reconfig_o,
    output logic module_disable_single_reconfig_o,
    // pins
    output logic bus_power_enable_output_o,
    output logic bus_power_enable_oe_n_o,
    output logic usb_ident_o,
    output logic port_ident_o,
    // reconfiguration grants
    output logic pps_write_en_o,
    output logic pmd_write_en_o,
    // reset and execution control
    output logic core_reset_o,
    output logic exec_inhibit_o,
    output logic brownout_reset_o,
    output logic [31:0] reset_cause_register_o
);
    // =========================================================
    // load sequencing
    logic loaded_reg;
    logic [31:0] word;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            loaded_reg <= 1'b0;
        end else begin
            loaded_reg <= 1'b1;
        end
    end

    cwp_word_store u_store (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .load_i(!loaded_reg),
        .nv_word_i(nv_word_i),
        .word_o(word)
    );

    assign device_config_word_three_o = word;
    assign user_tag_value_o = word[CWP_TAG_W-1:0];
    assign power_enable_pin_owner_sel_o = word[CWP_POWER_SEL_BIT];
    assign otg_ident_pin_owner_sel_o = word[CWP_IDENT_SEL_BIT];
    assign pin_select_single_reconfig_o = word[CWP_PPS_ONE_BIT];
    assign module_disable_single_reconfig_o = word[CWP_PMD_ONE_BIT];

    // =========================================================
    // pin ownership
    logic pins_off;
    assign pins_off = core_overvoltage_detect_i;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_power_enable_output_o <= 1'b0;
        end else if (word[CWP_POWER_SEL_BIT]) begin
            bus_power_enable_output_o <= usb_bus_power_i;
        end else begin
            bus_power_enable_output_o <= port_bus_power_i;
        end
    end

    assign bus_power_enable_oe_n_o = pins_off | rst_i;
    assign usb_ident_o = word[CWP_IDENT_SEL_BIT] & otg_ident_input_i;
    assign port_ident_o = !word[CWP_IDENT_SEL_BIT] & otg_ident_input_i;

    // =========================================================
    // one-way reconfiguration locks
    logic pps_done_reg;
    logic pmd_done_reg;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pps_done_reg <= 1'b0;
        end else if (pps_write_i && word[CWP_PPS_ONE_BIT]) begin
            pps_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pmd_done_reg <= 1'b0;
        end else if (pmd_write_i && word[CWP_PMD_ONE_BIT]) begin
            pmd_done_reg <= 1'b1;
        end
    end

    assign pps_write_en_o = pps_write_i & loaded_reg & !(word[CWP_PPS_ONE_BIT] & pps_done_reg);
    assign pmd_write_en_o = pmd_write_i & loaded_reg & !(word[CWP_PMD_ONE_BIT] & pmd_done_reg);

    // =========================================================
    // reset hold, start-up delay, brownout
    logic [CWP_CNT_W-1:0] startup_cnt_reg;
    logic [CWP_CNT_W-1:0] startup_load;
    assign startup_load = CWP_CNT_W'(STARTUP_CYCLES);

    assign core_reset_o = core_overvoltage_detect_i | regulator_low_i | !loaded_reg;
    assign brownout_reset_o = regulator_low_i;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            startup_cnt_reg <= CWP_CNT_W'(CWP_STARTUP_CYC);
        end else if (power_down_exit_i || core_reset_o) begin
            startup_cnt_reg <= startup_load;
        end else if (startup_cnt_reg != '0) begin
            startup_cnt_reg <= startup_cnt_reg - 1'b1;
        end
    end

    assign exec_inhibit_o = (startup_cnt_reg != '0) | core_reset_o;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reset_cause_register_o <= CWP_CAUSE_RESET;
        end else if (regulator_low_i) begin
            reset_cause_register_o[CWP_CAUSE_BROWNOUT_BIT] <= 1'b1;
        end else if (cause_clear_i) begin
            reset_cause_register_o[CWP_CAUSE_BROWNOUT_BIT] <= 1'b0;
        end
    end

    // =========================================================
    // checks
    property p_unimpl_zero;
        @(posedge ref_clk_i) disable iff (rst_i)
        device_config_word_three_o[27:16] == 12'h000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits not zero");

    property p_word_stable;
        @(posedge ref_clk_i) disable iff (rst_i)
        loaded_reg |=> $stable(device_config_word_three_o);
    endproperty
    a_word_stable: assert property (p_word_stable) else $error("config word changed while running");

    property p_power_owner;
        @(posedge ref_clk_i) disable iff (rst_i)
        loaded_reg && $stable(word) |=> bus_power_enable_output_o ==
            ($past(word[CWP_POWER_SEL_BIT]) ? $past(usb_bus_power_i) : $past(port_bus_power_i));
    endproperty
    a_power_owner: assert property (p_power_owner) else $error("power enable pin wrong owner");

    property p_ident_owner;
        @(posedge ref_clk_i) disable iff (rst_i)
        !word[CWP_IDENT_SEL_BIT] |-> !usb_ident_o;
    endproperty
    a_ident_owner: assert property (p_ident_owner) else $error("ident given to usb while port owns");

    logic always_false_pps;
    assign always_false_pps = !pps_write_en_o;

    property p_pps_once;
        @(posedge ref_clk_i) disable iff (rst_i)
        pps_write_en_o && word[CWP_PPS_ONE_BIT] |=> always_false_pps;
    endproperty
    a_pps_once: assert property (p_pps_once) else $error("second pin-select change granted");

    property p_pps_multi;
        @(posedge ref_clk_i) disable iff (rst_i)
        loaded_reg && pps_write_i && !word[CWP_PPS_ONE_BIT] |-> pps_write_en_o;
    endproperty
    a_pps_multi: assert property (p_pps_multi) else $error("repeat pin-select change refused");

    property p_pmd_multi;
        @(posedge ref_clk_i) disable iff (rst_i)
        loaded_reg && pmd_write_i && !word[CWP_PMD_ONE_BIT] |-> pmd_write_en_o;
    endproperty
    a_pmd_multi: assert property (p_pmd_multi) else $error("repeat module-disable change refused");

    property p_pmd_once;
        @(posedge ref_clk_i) disable iff (rst_i)
        pmd_done_reg && word[CWP_PMD_ONE_BIT] |-> !pmd_write_en_o;
    endproperty
    a_pmd_once: assert property (p_pmd_once) else $error("second module-disable change granted");

    property p_ov_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        core_overvoltage_detect_i |-> core_reset_o && bus_power_enable_oe_n_o;
    endproperty
    a_ov_hold: assert property (p_ov_hold) else $error("overvoltage not holding reset");

    property p_startup;
        @(posedge ref_clk_i) disable iff (rst_i)
        $fell(core_reset_o) |-> exec_inhibit_o [*8];
    endproperty
    a_startup: assert property (p_startup) else $error("execution resumed too soon");

    property p_inhibit_in_reset;
        @(posedge ref_clk_i) disable iff (rst_i)
        core_reset_o |-> exec_inhibit_o;
    endproperty
    a_inhibit_in_reset: assert property (p_inhibit_in_reset) else $error("execution allowed in reset");

    property p_wake_reload;
        @(posedge ref_clk_i) disable iff (rst_i)
        power_down_exit_i |=> startup_cnt_reg == startup_load;
    endproperty
    a_wake_reload: assert property (p_wake_reload) else $error("wake did not restart delay");

    property p_brownout_flag;
        @(posedge ref_clk_i) disable iff (rst_i)
        regulator_low_i |=> reset_cause_register_o[CWP_CAUSE_BROWNOUT_BIT];
    endproperty
    a_brownout_flag: assert property (p_brownout_flag) else $error("brownout not recorded");
endmodule

// ==== test/cwp_prog_host.sv ====
`timescale 1ns/100ps
// programmer or debug host: burns the stored word, reads the user tag back
module cwp_prog_host (
    // clock
    input wire logic ref_clk_i,
    // programming side
    input wire logic prog_en_i,
    input wire logic [31:0] prog_word_i,
    output logic [31:0] nv_word_o,
    // tag readback
    input wire logic [15:0] tag_i,
    output logic [15:0] tag_read_o
);
    initial nv_word_o = 32'h0;
    initial tag_read_o = 16'h0;
    always @(posedge ref_clk_i) begin
        if (prog_en_i) begin
            nv_word_o <= prog_word_i;
        end
        tag_read_o <= tag_i;
    end
endmodule

// ==== test/config_word_pin_ownership_bench.sv ====
`timescale 1ns/100ps
module config_word_pin_ownership_bench;
    import cwp_pkg::*;
    localparam int SC = 10;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic prog_en = 1'b0, ov = 1'b0, rlow = 1'b0, pdx = 1'b0, cclr = 1'b0;
    logic usb_bp = 1'b0, port_bp = 1'b0, ident = 1'b0, pps_w = 1'b0, pmd_w = 1'b0;
    logic [31:0] prog_word = 32'h0, nv_word, word, cause, w, exp_w;
    logic [15:0] tag, tag_rd;
    logic s31, s30, s29, s28, bp_o, oe_n, usb_id, port_id, pps_en, pmd_en, core_rst, inhibit, bor;
    int bad_count = 0, checks_done = 0, n;
    always #10 ref_clk_i = ~ref_clk_i;
    cwp_prog_host host (.ref_clk_i(ref_clk_i), .prog_en_i(prog_en), .prog_word_i(prog_word),
        .nv_word_o(nv_word), .tag_i(tag), .tag_read_o(tag_rd));
    cwp_config_word #(.STARTUP_CYCLES(SC)) DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .nv_word_i(nv_word),
        .core_overvoltage_detect_i(ov), .regulator_low_i(rlow), .power_down_exit_i(pdx),
        .cause_clear_i(cclr), .usb_bus_power_i(usb_bp), .port_bus_power_i(port_bp),
        .otg_ident_input_i(ident), .pps_write_i(pps_w), .pmd_write_i(pmd_w),
        .device_config_word_three_o(word), .user_tag_value_o(tag), .power_enable_pin_owner_sel_o(s31),
        .otg_ident_pin_owner_sel_o(s30), .pin_select_single_reconfig_o(s29),
        .module_disable_single_reconfig_o(s28), .bus_power_enable_output_o(bp_o),
        .bus_power_enable_oe_n_o(oe_n), .usb_ident_o(usb_id), .port_ident_o(port_id),
        .pps_write_en_o(pps_en), .pmd_write_en_o(pmd_en), .core_reset_o(core_rst),
        .exec_inhibit_o(inhibit), .brownout_reset_o(bor), .reset_cause_register_o(cause));
    task automatic tick();
        @(posedge ref_clk_i);
    endtask
    task automatic settle();
        @(negedge ref_clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run_len(output int k);
        k = 0;
        settle();
        while (inhibit === 1'b1 && k < 100) begin
            settle();
            k++;
        end
    endtask
    task automatic end_sim();
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
    initial begin
        void'($urandom(32'hdd4785e9));
        repeat (8) tick();
        for (int i = 0; i < 16; i++) begin
            w = {i[3:0], 28'($urandom())};
            exp_w = w & CWP_IMPL_MASK;
            tick();
            rst_i <= 1'b1;
            prog_word <= w;
            prog_en <= 1'b1;
            tick();
            prog_en <= 1'b0;
            tick();
            rst_i <= 1'b0;
            repeat (3) tick();
            settle();
            chk(word, exp_w);
            chk(32'(tag), 32'(w[15:0]));
            chk(32'(tag_rd), 32'(w[15:0]));
            chk(32'({s31, s30, s29, s28}), 32'(w[31:28]));
            tick();
            prog_word <= ~w;
            prog_en <= 1'b1;
            tick();
            prog_en <= 1'b0;
            repeat (2) tick();
            settle();
            chk(word, exp_w);
            for (int k = 0; k < 4; k++) begin
                tick();
                usb_bp <= k[0];
                port_bp <= k[1];
                ident <= k[0] ^ k[1];
                tick();
                settle();
                chk(32'(bp_o), 32'(w[31] ? k[0] : k[1]));
                chk(32'({usb_id, port_id}), 32'(w[30] ? {k[0] ^ k[1], 1'b0} : {1'b0, k[0] ^ k[1]}));
                chk(32'(oe_n), 32'h0);
            end
            for (int k = 0; k < 2; k++) begin
                tick();
                pps_w <= 1'b1;
                pmd_w <= 1'b1;
                settle();
                chk(32'(pps_en), k == 0 ? 32'h1 : 32'(!w[29]));
                chk(32'(pmd_en), k == 0 ? 32'h1 : 32'(!w[28]));
                tick();
                pps_w <= 1'b0;
                pmd_w <= 1'b0;
            end
            tick();
            rlow <= 1'b1;
            settle();
            chk(32'({bor, core_rst}), 32'h3);
            tick();
            rlow <= 1'b0;
            settle();
            chk(32'(cause[CWP_CAUSE_BROWNOUT_BIT]), 32'h1);
            tick();
            cclr <= 1'b1;
            tick();
            cclr <= 1'b0;
            settle();
            chk(cause, 32'h0);
            tick();
            ov <= 1'b1;
            settle();
            chk(32'({oe_n, core_rst, inhibit}), 32'h7);
            tick();
            ov <= 1'b0;
            run_len(n);
            chk(32'(n >= SC - 1 && n <= SC + 1), 32'h1);
            tick();
            pdx <= 1'b1;
            tick();
            pdx <= 1'b0;
            run_len(n);
            chk(32'(n >= SC - 2 && n <= SC + 1), 32'h1);
        end
        end_sim();
    end
endmodule
